// File: hdl/ubd_table.sv
// Buffer descriptor table engine with AHB-Lite access to the USB RAM
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module ubd_table
    import ubd_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    // AHB-Lite slave
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic        HREADY_IN,
    input  wire logic [31:0] HWDATA_IN,
    output logic [31:0]      HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    // Token from the serial engine
    input  wire logic        TOKEN_VALID_IN,
    input  wire logic [3:0]  TOKEN_EP_IN,
    input  wire logic [3:0]  TOKEN_PID_IN,
    input  wire logic        TOKEN_ODD_IN,
    output logic             TOKEN_READY_OUT,
    // Descriptor verdict
    output logic             DESC_VALID_OUT,
    output logic             DESC_OWNED_OUT,
    output logic             DESC_STALL_OUT,
    output logic             DESC_TOGGLE_OUT,
    output logic             DESC_SYNC_OUT,
    output logic [6:0]       DESC_COUNT_OUT,
    output logic [9:0]       DESC_BASE_OUT,
    // Buffer data access
    input  wire logic        DATA_REQ_IN,
    input  wire logic        DATA_WRITE_IN,
    input  wire logic [5:0]  DATA_INDEX_IN,
    input  wire logic [7:0]  DATA_WDATA_IN,
    output logic             DATA_ACK_OUT,
    output logic [7:0]       DATA_RDATA_OUT,
    // Completion
    input  wire logic        XFER_DONE_IN,
    input  wire logic        XFER_ABORT_IN,
    input  wire logic [6:0]  XFER_COUNT_IN,
    output logic             BUSY_OUT
);
    // =====================================================================
    // Engine states
    typedef enum logic [7:0] {
        S_IDLE    = 8'h01,
        S_RD_CTL  = 8'h02,
        S_RD_CNT  = 8'h04,
        S_RD_ADR  = 8'h08,
        S_CHECK   = 8'h10,
        S_XFER    = 8'h20,
        S_WB_CNT  = 8'h40,
        S_WB_CTL  = 8'h80
    } ubd_state_t;

    ubd_state_t  state_reg, state_next;
    logic [7:0]  base_reg, base_next;
    logic [3:0]  pid_reg, pid_next;
    logic [7:0]  ctl_reg, ctl_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic [7:0]  adr_reg, adr_next;
    logic [6:0]  rx_cnt_reg, rx_cnt_next;
    logic        rx_reg, rx_next;
    logic        dvalid_reg, dvalid_next;
    logic        ack_reg, ack_next;
    logic [3:0]  last_slot_reg, last_slot_next;
    logic        last_own_reg, last_own_next;
    logic        last_stall_reg, last_stall_next;
    logic [6:0]  ep_en_reg, ep_en_next;

    logic        map_valid;
    logic [7:0]  map_base;
    logic        ep_enabled;
    logic [7:0]  eng_addr;
    logic        eng_we;
    logic [7:0]  eng_wdata;
    logic [7:0]  eng_rdata;
    logic [9:0]  buf_addr;

    // =====================================================================
    // Descriptor location
    ubd_slot_map u_slot_map (
        .ep_in     (TOKEN_EP_IN),
        .dir_in_in (TOKEN_PID_IN == PID_IN),
        .odd_in    (TOKEN_ODD_IN),
        .valid_out (map_valid),
        .base_out  (map_base)
    );

    assign ep_enabled = (TOKEN_EP_IN < 4'(EP_COUNT)) && ep_en_reg[TOKEN_EP_IN[2:0]];
    assign TOKEN_READY_OUT = (state_reg == S_IDLE);
    assign BUSY_OUT        = (state_reg != S_IDLE);
    assign DATA_ACK_OUT    = ack_reg;
    assign DATA_RDATA_OUT  = eng_rdata;

    // Buffer address: base byte shifted to bits 9:4, plus the 6-bit packet index added on
    assign buf_addr = {adr_reg[5:0], 4'h0} + {4'h0, DATA_INDEX_IN};

    // =====================================================================
    // Engine RAM port
    always_comb begin
        eng_addr  = base_reg;
        eng_we    = 1'b0;
        eng_wdata = 8'h00;
        case (state_reg)
            S_IDLE: begin
                eng_addr = map_base;
            end
            S_RD_CTL: begin
                eng_addr = base_reg + {6'h00, OFF_CNT};
            end
            S_RD_CNT: begin
                eng_addr = base_reg + {6'h00, OFF_ADR};
            end
            S_XFER: begin
                // Local offset only; an address past the RAM wraps
                eng_addr  = buf_addr[RAM_AW-1:0];
                eng_we    = DATA_REQ_IN && DATA_WRITE_IN;
                eng_wdata = DATA_WDATA_IN;
            end
            S_WB_CNT: begin
                eng_addr  = base_reg + {6'h00, OFF_CNT};
                eng_we    = 1'b1;
                eng_wdata = {1'b0, rx_cnt_reg};
            end
            S_WB_CTL: begin
                eng_addr  = base_reg + {6'h00, OFF_CTL};
                eng_we    = 1'b1;
                // Ownership back to the CPU, toggle kept, token PID recorded
                eng_wdata = {1'b0, ctl_reg[TOGGLE_BIT], pid_reg, 2'b00};
            end
            default: begin
                eng_addr = base_reg;
            end
        endcase
    end

    // =====================================================================
    // Engine sequence
    always_comb begin
        state_next      = state_reg;
        base_next       = base_reg;
        pid_next        = pid_reg;
        ctl_next        = ctl_reg;
        cnt_next        = cnt_reg;
        adr_next        = adr_reg;
        rx_cnt_next     = rx_cnt_reg;
        rx_next         = rx_reg;
        dvalid_next     = 1'b0;
        ack_next        = 1'b0;
        last_slot_next  = last_slot_reg;
        last_own_next   = last_own_reg;
        last_stall_next = last_stall_reg;
        case (state_reg)
            S_IDLE: begin
                // Tokens for disabled or unmapped endpoints are dropped
                if (TOKEN_VALID_IN && map_valid && ep_enabled) begin
                    base_next  = map_base;
                    pid_next   = TOKEN_PID_IN;
                    rx_next    = (TOKEN_PID_IN != PID_IN);
                    state_next = S_RD_CTL;
                end
            end
            S_RD_CTL: begin
                ctl_next   = eng_rdata;
                state_next = S_RD_CNT;
            end
            S_RD_CNT: begin
                cnt_next   = eng_rdata;
                state_next = S_RD_ADR;
            end
            S_RD_ADR: begin
                adr_next   = eng_rdata;
                state_next = S_CHECK;
            end
            S_CHECK: begin
                dvalid_next     = 1'b1;
                last_slot_next  = 4'(base_reg / DESC_BYTES);
                last_own_next   = ctl_reg[OWN_BIT];
                last_stall_next = ctl_reg[STALL_BIT];
                // Not owned, or stalled: nothing is consumed or written
                if (ctl_reg[OWN_BIT] && !ctl_reg[STALL_BIT]) begin
                    state_next = S_XFER;
                end else begin
                    state_next = S_IDLE;
                end
            end
            S_XFER: begin
                ack_next = DATA_REQ_IN;
                if (XFER_ABORT_IN) begin
                    // Retried later, so the descriptor is left as it was
                    state_next = S_IDLE;
                end else if (XFER_DONE_IN) begin
                    // Clip to the module's packet limit
                    rx_cnt_next = (XFER_COUNT_IN > MAX_PACKET) ? MAX_PACKET
                                                                : XFER_COUNT_IN;
                    state_next  = rx_reg ? S_WB_CNT : S_WB_CTL;
                end
            end
            S_WB_CNT: begin
                state_next = S_WB_CTL;
            end
            S_WB_CTL: begin
                state_next = S_IDLE;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg      <= S_IDLE;
            base_reg       <= 8'h00;
            pid_reg        <= 4'h0;
            ctl_reg        <= 8'h00;
            cnt_reg        <= 8'h00;
            adr_reg        <= 8'h00;
            rx_cnt_reg     <= 7'h00;
            rx_reg         <= 1'b0;
            dvalid_reg     <= 1'b0;
            ack_reg        <= 1'b0;
            last_slot_reg  <= 4'h0;
            last_own_reg   <= 1'b0;
            last_stall_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            base_reg       <= base_next;
            pid_reg        <= pid_next;
            ctl_reg        <= ctl_next;
            cnt_reg        <= cnt_next;
            adr_reg        <= adr_next;
            rx_cnt_reg     <= rx_cnt_next;
            rx_reg         <= rx_next;
            dvalid_reg     <= dvalid_next;
            ack_reg        <= ack_next;
            last_slot_reg  <= last_slot_next;
            last_own_reg   <= last_own_next;
            last_stall_reg <= last_stall_next;
        end
    end

    // =====================================================================
    // Descriptor verdict, one-cycle pulse with held fields
    always_comb begin
        DESC_VALID_OUT  = dvalid_reg;
        DESC_OWNED_OUT  = last_own_reg;
        DESC_STALL_OUT  = last_stall_reg && last_own_reg;
        DESC_TOGGLE_OUT = ctl_reg[TOGGLE_BIT];
        DESC_SYNC_OUT   = ctl_reg[SYNC_BIT];
        DESC_COUNT_OUT  = (cnt_reg > {1'b0, MAX_PACKET}) ? MAX_PACKET
                                                           : cnt_reg[6:0];
        DESC_BASE_OUT   = {adr_reg[5:0], 4'h0};
    end

    // =====================================================================
    // AHB-Lite slave, zero wait states
    logic        ap_take;
    logic        ap_ram;
    logic        dp_write_reg, dp_write_next;
    logic        dp_ram_reg, dp_ram_next;
    logic [31:0] dp_addr_reg, dp_addr_next;
    logic [31:0] reg_rdata_reg, reg_rdata_next;
    logic        cpu_we;
    logic [7:0]  cpu_wdata;

    assign ap_take = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NSEQ);
    assign ap_ram  = HADDR_IN < RAM_SPAN;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;

    always_comb begin
        dp_write_next  = 1'b0;
        dp_ram_next    = 1'b0;
        dp_addr_next   = dp_addr_reg;
        reg_rdata_next = 32'h0000_0000;
        if (ap_take) begin
            dp_write_next = HWRITE_IN;
            dp_ram_next   = ap_ram;
            dp_addr_next  = HADDR_IN;
            if (HADDR_IN == REG_EP_EN) begin
                reg_rdata_next = {25'h0, ep_en_reg};
            end else if (HADDR_IN == REG_STATUS) begin
                reg_rdata_next = {24'h0, BUSY_OUT, last_own_reg, last_stall_reg,
                                  1'b0, last_slot_reg};
            end
        end
    end

    // No lockout while the engine owns a descriptor; firmware must stay off
    always_comb begin
        cpu_we    = dp_write_reg && dp_ram_reg;
        cpu_wdata = HWDATA_IN[7:0];
        if (is_ctl_byte(dp_addr_reg[9:2])) begin
            cpu_wdata = HWDATA_IN[7:0] & CTL_WMASK;
        end
    end

    always_comb begin
        ep_en_next = ep_en_reg;
        if (dp_write_reg && dp_addr_reg == REG_EP_EN) begin
            ep_en_next = HWDATA_IN[EP_COUNT-1:0];
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dp_write_reg  <= 1'b0;
            dp_ram_reg    <= 1'b0;
            dp_addr_reg   <= 32'h0000_0000;
            reg_rdata_reg <= 32'h0000_0000;
            ep_en_reg     <= EP_EN_RESET;
        end else begin
            dp_write_reg  <= dp_write_next;
            dp_ram_reg    <= dp_ram_next;
            dp_addr_reg   <= dp_addr_next;
            reg_rdata_reg <= reg_rdata_next;
            ep_en_reg     <= ep_en_next;
        end
    end

    logic [7:0] cpu_rdata;

    // Reads of the RAM are issued in the address phase, so data is ready next
    ubd_ram #(
        .AW (RAM_AW),
        .DW (8)
    ) u_ram (
        .clk_in        (CLK_IN),
        .rst_n_in      (RST_N_IN),
        .cpu_raddr_in  (HADDR_IN[9:2]),
        .cpu_we_in     (cpu_we),
        .cpu_waddr_in  (dp_addr_reg[9:2]),
        .cpu_wdata_in  (cpu_wdata),
        .cpu_rdata_out (cpu_rdata),
        .eng_addr_in   (eng_addr),
        .eng_we_in     (eng_we),
        .eng_wdata_in  (eng_wdata),
        .eng_rdata_out (eng_rdata)
    );

    assign HRDATA_OUT = dp_ram_reg ? {24'h0, cpu_rdata} : reg_rdata_reg;
endmodule : ubd_table

// File: shared/ubd_pkg.sv
// Package for the buffer descriptor table logic: map, field layout, codes
package ubd_pkg;
    // =====================================================================
    // USB RAM organisation
    localparam int          RAM_AW       = 8;
    localparam int          RAM_DEPTH    = 256;
    localparam logic [7:0]  TABLE_LAST   = 8'h1d;
    localparam logic [7:0]  RSVD_FIRST   = 8'h1e;
    localparam logic [7:0]  BUF_FIRST    = 8'h20;
    localparam logic [7:0]  DESC_BYTES   = 8'h03;
    localparam logic [1:0]  OFF_CTL      = 2'h0;
    localparam logic [1:0]  OFF_CNT      = 2'h1;
    localparam logic [1:0]  OFF_ADR      = 2'h2;
    // =====================================================================
    // Control byte layout
    localparam int          OWN_BIT      = 7;
    localparam int          TOGGLE_BIT   = 6;
    localparam int          SYNC_BIT     = 3;
    localparam int          STALL_BIT    = 2;
    localparam int          PID_LSB      = 2;
    localparam logic [7:0]  CTL_WMASK    = 8'hfc;
    localparam logic [3:0]  PID_OUT      = 4'h1;
    localparam logic [3:0]  PID_IN       = 4'h9;
    localparam logic [3:0]  PID_SETUP    = 4'hd;
    localparam logic [6:0]  MAX_PACKET   = 7'h40;
    localparam int          BASE_LSB     = 4;
    // =====================================================================
    // Endpoints
    localparam int          EP_COUNT     = 7;
    localparam logic [3:0]  EP_SINGLE_LO = 4'h1;
    localparam logic [3:0]  EP_SINGLE_HI = 4'h4;
    localparam logic [3:0]  EP_DBL_A     = 4'h5;
    localparam logic [3:0]  EP_DBL_B     = 4'h6;
    localparam logic [3:0]  SLOT_EP0_OUT = 4'h1;
    localparam logic [3:0]  SLOT_EP5_EVN = 4'h6;
    localparam logic [3:0]  SLOT_EP6_EVN = 4'h8;
    // =====================================================================
    // Bus map: RAM byte i sits at byte address 4*i
    localparam logic [31:0] RAM_SPAN     = 32'h0000_0400;
    localparam logic [31:0] REG_EP_EN    = 32'h0000_0400;
    localparam logic [31:0] REG_STATUS   = 32'h0000_0404;
    localparam logic [6:0]  EP_EN_RESET  = 7'h00;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

    // True for the control byte of a descriptor slot
    function automatic logic is_ctl_byte(input logic [7:0] a);
        is_ctl_byte = (a <= TABLE_LAST) && ((a % DESC_BYTES) == 8'h00);
    endfunction : is_ctl_byte
endpackage : ubd_pkg

// File: hdl/ubd_slot_map.sv
// Maps endpoint, direction and even/odd choice onto a descriptor base offset
`timescale 1ns/1ps
module ubd_slot_map
    import ubd_pkg::*;
(
    // Token
    input  wire logic [3:0] ep_in,
    input  wire logic       dir_in_in,
    input  wire logic       odd_in,
    // Location
    output logic            valid_out,
    output logic [7:0]      base_out
);
    logic [3:0] slot;

    always_comb begin
        valid_out = 1'b1;
        slot      = 4'h0;
        if (ep_in == 4'h0) begin
            slot = dir_in_in ? 4'h0 : SLOT_EP0_OUT;
        end else if (ep_in >= EP_SINGLE_LO && ep_in <= EP_SINGLE_HI) begin
            slot = ep_in + 4'h1;
        end else if (ep_in == EP_DBL_A) begin
            slot = SLOT_EP5_EVN + {3'h0, odd_in};
        end else if (ep_in == EP_DBL_B) begin
            slot = SLOT_EP6_EVN + {3'h0, odd_in};
        end else begin
            valid_out = 1'b0;
        end
        base_out = {4'h0, slot} * DESC_BYTES;
    end
endmodule : ubd_slot_map

// File: hdl/ubd_ram.sv
// Local USB RAM with a CPU port and a serial engine port
`timescale 1ns/1ps
module ubd_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    // CPU port
    input  wire logic [AW-1:0] cpu_raddr_in,
    input  wire logic          cpu_we_in,
    input  wire logic [AW-1:0] cpu_waddr_in,
    input  wire logic [DW-1:0] cpu_wdata_in,
    output logic [DW-1:0]      cpu_rdata_out,
    // Engine port
    input  wire logic [AW-1:0] eng_addr_in,
    input  wire logic          eng_we_in,
    input  wire logic [DW-1:0] eng_wdata_in,
    output logic [DW-1:0]      eng_rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] cpu_rdata_next;
    logic [DW-1:0] eng_rdata_next;

    // Both ports served every cycle, so neither side is ever held off
    always_comb begin
        cpu_rdata_next = mem[cpu_raddr_in];
        eng_rdata_next = mem[eng_addr_in];
        if (cpu_we_in && cpu_waddr_in == cpu_raddr_in) begin
            cpu_rdata_next = cpu_wdata_in;
        end
    end

    // Engine write wins a same-address collision
    always_ff @(posedge clk_in) begin
        if (cpu_we_in && !(eng_we_in && eng_addr_in == cpu_waddr_in)) begin
            mem[cpu_waddr_in] <= cpu_wdata_in;
        end
        if (eng_we_in) begin
            mem[eng_addr_in] <= eng_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_rdata_out <= '0;
            eng_rdata_out <= '0;
        end else begin
            cpu_rdata_out <= cpu_rdata_next;
            eng_rdata_out <= eng_rdata_next;
        end
    end
endmodule : ubd_ram

// File: verif/ubd_table_chk.sv
// Concurrent checks on the descriptor table ports
`timescale 1ns/1ps
module ubd_table_chk (
    // Clock, reset and bus answer
    input wire logic       CLK_IN, RST_N_IN, HREADYOUT_OUT, HRESP_OUT,
    // Token and verdict
    input wire logic       TOKEN_VALID_IN, TOKEN_READY_OUT, BUSY_OUT,
    input wire logic       DESC_VALID_OUT, DESC_OWNED_OUT, DESC_STALL_OUT,
    input wire logic [6:0] DESC_COUNT_OUT,
    input wire logic [9:0] DESC_BASE_OUT,
    // Data and completion
    input wire logic       DATA_REQ_IN, DATA_ACK_OUT, XFER_DONE_IN
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // =====================================================================
    // Transfer phase tracker
    logic xfer_reg, xfer_next, take;
    assign take = TOKEN_VALID_IN && TOKEN_READY_OUT;
    always_comb begin
        xfer_next = DESC_VALID_OUT ? (DESC_OWNED_OUT && !DESC_STALL_OUT) : xfer_reg;
        if (!BUSY_OUT) begin
            xfer_next = 1'b0;
        end
    end
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            xfer_reg <= 1'b0;
        end else begin
            xfer_reg <= xfer_next;
        end
    end
    // =====================================================================
    // Assertions
    sequence s_verdict; DESC_VALID_OUT; endsequence
    sequence s_ended; XFER_DONE_IN && xfer_reg; endsequence
    a_fetch_latency: assert property (s_verdict |-> $past(take, 5))
        else $error("verdict without a token five cycles before");
    a_unowned_idle: assert property ((s_verdict and !DESC_OWNED_OUT) |=> TOKEN_READY_OUT)
        else $error("unowned descriptor was consumed");
    a_stall_kept: assert property ((s_verdict and DESC_STALL_OUT) |->
        DESC_OWNED_OUT ##1 TOKEN_READY_OUT)
        else $error("stalled descriptor was consumed");
    a_count_clip: assert property (s_verdict |-> DESC_COUNT_OUT <= 7'h40)
        else $error("byte count above packet limit");
    a_base_align: assert property (s_verdict |-> DESC_BASE_OUT[3:0] == 4'h0)
        else $error("buffer base not aligned");
    a_data_ack: assert property (xfer_reg && DATA_REQ_IN && !XFER_DONE_IN |=> DATA_ACK_OUT)
        else $error("buffer request not acknowledged");
    a_done_release: assert property (s_ended |-> ##[1:3] TOKEN_READY_OUT)
        else $error("descriptor not returned after completion");
    a_no_lockout: assert property (BUSY_OUT |-> HREADYOUT_OUT && !HRESP_OUT)
        else $error("cpu access stalled while engine busy");
endmodule : ubd_table_chk

bind ubd_table ubd_table_chk chk_u (.*);

// File: verif/ubd_eng_model.sv
// Serial engine model: issues tokens, moves packet data, reports completion
`timescale 1ns/1ps
module ubd_eng_model
    import ubd_pkg::*;
(
    // Clock and token
    input  wire logic       clk_in, trdy_in,
    output logic            tv_out, todd_out,
    output logic [3:0]      tep_out, tpid_out,
    // Verdict
    input  wire logic       dv_in, own_in, stl_in, ack_in,
    input  wire logic [6:0] cnt_in,
    input  wire logic [7:0] rd_in,
    // Data and completion
    output logic            dreq_out, dwr_out, done_out,
    output logic [5:0]      didx_out,
    output logic [7:0]      dwd_out,
    output logic [6:0]      xcnt_out
);
    logic       got;
    logic [7:0] rd_last;
    initial begin
        {tv_out, todd_out, tep_out, tpid_out, dreq_out, dwr_out, done_out} = '0;
        {didx_out, dwd_out, xcnt_out} = '0;
    end
    always @(posedge clk_in) begin
        if (ack_in) begin
            rd_last <= rd_in;
        end
    end
    // =====================================================================
    // One token; slow spaces the buffer requests
    task automatic run(input logic [3:0] ep, pid, input logic odd, input int n, slow);
        int k;
        got = 1'b0;
        @(posedge clk_in);
        tv_out   <= 1'b1;
        tep_out  <= ep;
        tpid_out <= pid;
        todd_out <= odd;
        do @(posedge clk_in); while (trdy_in !== 1'b1);
        tv_out <= 1'b0;
        for (k = 0; k < 8 && !got; k++) begin
            @(posedge clk_in);
            got = dv_in;
        end
        if (got && own_in && !stl_in) begin
            if (pid == PID_IN) begin
                n = cnt_in;
            end
            for (k = 0; k < n; k++) begin
                if (slow != 0) begin
                    dreq_out <= 1'b0;
                    @(posedge clk_in);
                end
                dreq_out <= 1'b1;
                dwr_out  <= (pid != PID_IN);
                didx_out <= k[5:0];
                dwd_out  <= 8'ha0 + k[7:0];
                @(posedge clk_in);
            end
            dreq_out <= 1'b0;
            dwd_out  <= ~dwd_out; // Released data never shows a stale byte
            done_out <= 1'b1;
            xcnt_out <= n[6:0];
            @(posedge clk_in);
            done_out <= 1'b0;
        end
        for (k = 0; k < 8 && !trdy_in; k++) @(posedge clk_in);
    endtask : run
endmodule : ubd_eng_model

// File: verif/tb_usb_buffer_descriptor_table.sv
// Self-checking bench for the descriptor table with a serial engine model
`timescale 1ns/1ps
module tb_usb_buffer_descriptor_table;
    import ubd_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hready, hresp, busy;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic        tv, todd, trdy, dv, own, stl, tgl, syn, dreq, dwr, ack, done;
    logic [3:0]  tep, tpid;
    logic [6:0]  dcnt, xcnt;
    logic [9:0]  base;
    logic [5:0]  didx;
    logic [7:0]  dwd, rdat;
    int          errors = 0, samples_checked = 0, r, b;
    localparam logic [3:0] R_EP [6] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h5, 4'h6};
    localparam logic [3:0] R_PID [6] = '{PID_IN, PID_OUT, PID_SETUP, PID_IN, PID_OUT, PID_OUT};
    localparam int R_OFF [6] = '{0, 3, 3, 9, 21, 24};
    always #12.5 clk = ~clk;
    ubd_table dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hready),
        .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .TOKEN_VALID_IN(tv), .TOKEN_EP_IN(tep), .TOKEN_PID_IN(tpid), .TOKEN_ODD_IN(todd),
        .TOKEN_READY_OUT(trdy), .DESC_VALID_OUT(dv), .DESC_OWNED_OUT(own),
        .DESC_STALL_OUT(stl), .DESC_TOGGLE_OUT(tgl), .DESC_SYNC_OUT(syn),
        .DESC_COUNT_OUT(dcnt), .DESC_BASE_OUT(base), .DATA_REQ_IN(dreq), .DATA_WRITE_IN(dwr),
        .DATA_INDEX_IN(didx), .DATA_WDATA_IN(dwd), .DATA_ACK_OUT(ack), .DATA_RDATA_OUT(rdat),
        .XFER_DONE_IN(done), .XFER_ABORT_IN(1'b0), .XFER_COUNT_IN(xcnt), .BUSY_OUT(busy));
    ubd_eng_model eng_u (.clk_in(clk), .trdy_in(trdy), .tv_out(tv), .todd_out(todd),
        .tep_out(tep), .tpid_out(tpid), .dv_in(dv), .own_in(own), .stl_in(stl), .ack_in(ack),
        .cnt_in(dcnt), .rd_in(rdat), .dreq_out(dreq), .dwr_out(dwr), .done_out(done),
        .didx_out(didx), .dwd_out(dwd), .xcnt_out(xcnt));
    // =====================================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] s, e, input string nm);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic ahb(input logic w, input int a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        htrans <= HTRANS_NSEQ;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    task automatic wr(input int a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input int a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e, nm);
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // =====================================================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(32'h400, {25'h0, EP_EN_RESET}, "enable reset");
        rd(32'h1000, 32'h0, "unmapped");
        wr(0, 32'hff);
        rd(0, 32'hfc, "control mask");
        wr(4 * 32'h1e, 32'h3c);
        rd(4 * 32'h1e, 32'h3c, "reserved byte");
        $display("test map done");
        wr(32'h400, 32'h77);
        wr(4 * 12, 32'h4c);
        wr(4 * 13, 32'h0);
        eng_u.run(4'h3, PID_OUT, 1'b0, 1, 0);
        chk(eng_u.got, 1'b0, "disabled token");
        wr(32'h400, 32'h7f);
        eng_u.run(4'h3, PID_OUT, 1'b0, 1, 0);
        chk({own, stl}, 2'b00, "unowned verdict");
        rd(4 * 12, 32'h4c, "unowned control");
        wr(4 * 7, 32'h50);
        wr(4 * 8, 32'h09);
        wr(4 * 6, 32'h84);
        eng_u.run(4'h1, PID_IN, 1'b0, 1, 0);
        chk({stl, syn}, 2'b10, "stall verdict");
        chk(dcnt, 7'h40, "clipped count");
        rd(4 * 6, 32'h84, "stalled control");
        rd(4 * 7, 32'h50, "stalled count");
        rd(32'h404, 32'h62, "status");
        $display("test ownership and stall done");
        for (r = 0; r < 6; r++) begin
            b = 32 + 16 * r;
            wr(4 * (R_OFF[r] + 1), 32'h4);
            wr(4 * (R_OFF[r] + 2), 2 + r);
            wr(4 * (b + 3), 32'h5a + r);
            wr(4 * R_OFF[r], 32'hc8);
            eng_u.run(R_EP[r], R_PID[r], r == 4, r + 1, r == 5);
            chk(base, b, "buffer base");
            chk({tgl, syn}, 2'b11, "toggle and sync");
            rd(4 * R_OFF[r], 32'h40 | {R_PID[r], 2'b00}, "control writeback");
            rd(4 * (R_OFF[r] + 2), 2 + r, "base byte");
            if (R_PID[r] == PID_IN) begin
                chk(eng_u.rd_last, 32'h5a + r, "sent data");
                rd(4 * (R_OFF[r] + 1), 32'h4, "sent count");
            end else begin
                rd(4 * (R_OFF[r] + 1), r + 1, "received count");
                rd(4 * (b + r), 32'ha0 + r, "received data");
            end
        end
        $display("test transfers done");
        tally_and_finish();
    end
    // Cuts a hang short; tests need well under this span
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule : tb_usb_buffer_descriptor_table
